// [hdl/counter_timer_defines.svh]
`ifndef COUNTER_TIMER_DEFINES_SVH
`define COUNTER_TIMER_DEFINES_SVH
// ----------------------------------------
// Event sources
// ----------------------------------------
`define SRC_COUNT 19
`define SRC_OFF 5'h00
`define SRC_LIMIT 5'h13
// ----------------------------------------
// Activation modes
// ----------------------------------------
`define ACT_LOW 3'h0
`define ACT_HIGH 3'h1
`define ACT_FALL 3'h2
`define ACT_RISE 3'h3
`define ACT_ANY 3'h4
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_UNIT_SEL 6'h00
`define OFS_INC_SRC 6'h04
`define OFS_INC_ACT 6'h08
`define OFS_DELAY 6'h0c
`define OFS_LENGTH 6'h10
`define OFS_BEG_SRC 6'h14
`define OFS_BEG_ACT 6'h18
`define OFS_CLR_SRC 6'h1c
`define OFS_CLR_ACT 6'h20
`define OFS_COUNT 6'h24
`define OFS_STATE 6'h28
`define OFS_AT_CLEAR 6'h2c
`define OFS_IRQ_STATUS 6'h30
`define OFS_IRQ_MASK 6'h34
`define IRQ_BITS 4
`define ALL_LANES 4'hf
`endif

// [hdl/ctr_pkg.sv]
package ctr_pkg;
  typedef enum logic [4:0] {
    st_idle = 5'h01,
    st_trigger_wait = 5'h02,
    st_active = 5'h04,
    st_completed = 5'h08,
    st_overflow = 5'h10
  } unit_state_t;
endpackage : ctr_pkg

// [hdl/dual_event_counter_timer.sv]
// The register offsets and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`include "counter_timer_defines.svh"
// Notes on behaviour
// - Two independent units exist and a selector picks which one the per-unit registers reach.
// - A unit counts a chosen source among tick, lines, software outputs, unit events, logic outputs and exposure phases.
// - Increments are qualified by level low, level high, falling, rising or any edge.
// - The start event is raised once the delay count of increments has passed.
// - The end event is raised once the duration count of further increments has passed.
// - Choosing a begin source turns the clear source off, and the other way round.
// - A unit starts counting when its chosen begin source fires.
// - The begin source is qualified by the same five activation modes.
// - A unit clears its count when its chosen clear source fires.
// - The clear source is qualified by the same five activation modes.
// - The selected unit's live count can be read at any time.
// - The selected unit's operating state can be read as an enumerated value.
// - At a clear the count is captured and stays readable until the next clear.
module dual_event_counter_timer #(
  parameter int COUNT_WIDTH = 32
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic microsecond_tick,
  input wire logic [3:0] line_in,
  input wire logic [3:0] software_output,
  input wire logic [1:0] programmable_logic_output,
  input wire logic exposure_begin,
  input wire logic exposure_finish,
  input wire logic awaiting_frame_trigger,
  output logic [1:0] delay_done_event,
  output logic [1:0] run_done_event
);
  // ----------------------------------------
  // Line input synchronisers
  // ----------------------------------------
  logic [3:0] line_s1;
  logic [3:0] line_s2;
  logic [3:0] line_s3;
  logic [3:0] line_ok;
  wire [3:0] line_agree = ~(line_s2 ^ line_s3);
  wire [3:0] next_line_ok = (line_ok & ~line_agree) | (line_s3 & line_agree);

  // Change accepted only when stages two and three agree
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      line_s1 <= '0;
      line_s2 <= '0;
      line_s3 <= '0;
      line_ok <= '0;
    end else begin
      line_s1 <= line_in;
      line_s2 <= line_s1;
      line_s3 <= line_s2;
      line_ok <= next_line_ok;
    end
  end

  // Own events come from flops, so the feedback loop is registered
  wire [`SRC_COUNT-1:0] sources = {
    awaiting_frame_trigger,
    exposure_finish,
    exposure_begin,
    programmable_logic_output,
    run_done_event,
    delay_done_event,
    software_output,
    line_ok,
    microsecond_tick,
    1'b0
  };

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic ack;
  logic usel;
  logic [4:0] inc_src [2];
  logic [2:0] inc_act [2];
  logic [4:0] beg_src [2];
  logic [2:0] beg_act [2];
  logic [4:0] clr_src [2];
  logic [2:0] clr_act [2];
  logic [COUNT_WIDTH-1:0] delay_cfg [2];
  logic [COUNT_WIDTH-1:0] length_cfg [2];
  logic [`IRQ_BITS-1:0] irq_status;
  logic [`IRQ_BITS-1:0] irq_mask;
  logic [COUNT_WIDTH-1:0] count_now [2];
  logic [COUNT_WIDTH-1:0] count_clr [2];
  ctr_pkg::unit_state_t state_now [2];

  // One wait state: answer at the second edge of a request
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  wire wr_ok = avs_write & ack & (avs_byteenable == `ALL_LANES);
  wire [31:0] wd = avs_writedata;
  wire hit_sel = avs_address == `OFS_UNIT_SEL;
  wire hit_inc_src = avs_address == `OFS_INC_SRC;
  wire hit_inc_act = avs_address == `OFS_INC_ACT;
  wire hit_delay = avs_address == `OFS_DELAY;
  wire hit_length = avs_address == `OFS_LENGTH;
  wire hit_beg_src = avs_address == `OFS_BEG_SRC;
  wire hit_beg_act = avs_address == `OFS_BEG_ACT;
  wire hit_clr_src = avs_address == `OFS_CLR_SRC;
  wire hit_clr_act = avs_address == `OFS_CLR_ACT;
  wire hit_count = avs_address == `OFS_COUNT;
  wire hit_state = avs_address == `OFS_STATE;
  wire hit_at_clear = avs_address == `OFS_AT_CLEAR;
  wire hit_irq_status = avs_address == `OFS_IRQ_STATUS;
  wire hit_irq_mask = avs_address == `OFS_IRQ_MASK;

  // Unmapped addresses read zero
  wire [31:0] read_mux =
    hit_sel ? {31'h0000_0000, usel} :
    hit_inc_src ? {27'h000_0000, inc_src[usel]} :
    hit_inc_act ? {29'h000_0000, inc_act[usel]} :
    hit_delay ? 32'(delay_cfg[usel]) :
    hit_length ? 32'(length_cfg[usel]) :
    hit_beg_src ? {27'h000_0000, beg_src[usel]} :
    hit_beg_act ? {29'h000_0000, beg_act[usel]} :
    hit_clr_src ? {27'h000_0000, clr_src[usel]} :
    hit_clr_act ? {29'h000_0000, clr_act[usel]} :
    hit_count ? 32'(count_now[usel]) :
    hit_state ? {27'h000_0000, state_now[usel]} :
    hit_at_clear ? 32'(count_clr[usel]) :
    hit_irq_status ? {28'h000_0000, irq_status} :
    hit_irq_mask ? {28'h000_0000, irq_mask} :
    32'h0000_0000;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ack <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
      avs_readdata <= read_mux;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      usel <= 1'b0;
      irq_mask <= '0;
      for (int i = 0; i < 2; i++) begin
        inc_src[i] <= `SRC_OFF;
        inc_act[i] <= `ACT_RISE;
        beg_src[i] <= `SRC_OFF;
        beg_act[i] <= `ACT_RISE;
        clr_src[i] <= `SRC_OFF;
        clr_act[i] <= `ACT_RISE;
        delay_cfg[i] <= '0;
        length_cfg[i] <= '0;
      end
    end else if (wr_ok) begin
      if (hit_sel) usel <= wd[0];
      if (hit_inc_src) inc_src[usel] <= wd[4:0];
      if (hit_inc_act) inc_act[usel] <= wd[2:0];
      if (hit_delay) delay_cfg[usel] <= wd[COUNT_WIDTH-1:0];
      if (hit_length) length_cfg[usel] <= wd[COUNT_WIDTH-1:0];
      if (hit_beg_act) beg_act[usel] <= wd[2:0];
      if (hit_clr_act) clr_act[usel] <= wd[2:0];
      if (hit_irq_mask) irq_mask <= wd[`IRQ_BITS-1:0];
      if (hit_beg_src) begin
        beg_src[usel] <= wd[4:0];
        if (wd[4:0] != `SRC_OFF) clr_src[usel] <= `SRC_OFF;
      end
      if (hit_clr_src) begin
        clr_src[usel] <= wd[4:0];
        if (wd[4:0] != `SRC_OFF) beg_src[usel] <= `SRC_OFF;
      end
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  wire [`IRQ_BITS-1:0] irq_events = {run_done_event, delay_done_event};
  wire [`IRQ_BITS-1:0] irq_clear = (wr_ok && hit_irq_status) ? wd[`IRQ_BITS-1:0] : '0;

  // A new event beats a same-cycle clear
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      irq_status <= '0;
    end else begin
      irq_status <= irq_events | (irq_status & ~irq_clear);
    end
  end
  assign irq = |(irq_status & irq_mask);

  // ----------------------------------------
  // Counter units
  // ----------------------------------------
  for (genvar u = 0; u < 2; u++) begin : g_unit
    event_count_unit #(
      .COUNT_WIDTH(COUNT_WIDTH)
    ) unit (
      .ref_clk(ref_clk),
      .reset(reset),
      .sources(sources),
      .increment_source_select(inc_src[u]),
      .increment_activation_mode(inc_act[u]),
      .begin_source_select(beg_src[u]),
      .begin_activation_mode(beg_act[u]),
      .clear_source_select(clr_src[u]),
      .clear_activation_mode(clr_act[u]),
      .start_delay_count(delay_cfg[u]),
      .run_length_count(length_cfg[u]),
      .delay_done_event(delay_done_event[u]),
      .run_done_event(run_done_event[u]),
      .present_count(count_now[u]),
      .count_at_clear(count_clr[u]),
      .unit_state(state_now[u])
    );
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_exclusive;
    @(posedge ref_clk) disable iff (reset)
    !(beg_src[0] != `SRC_OFF && clr_src[0] != `SRC_OFF) &&
    !(beg_src[1] != `SRC_OFF && clr_src[1] != `SRC_OFF);
  endproperty
  a_exclusive: assert property (p_exclusive) else $error("begin and clear both active");
  property p_answer;
    @(posedge ref_clk) disable iff (reset)
    ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");
  property p_count_read;
    @(posedge ref_clk) disable iff (reset)
    (avs_read && avs_waitrequest && hit_count)
      |=> avs_readdata == 32'($past(count_now[usel]));
  endproperty
  a_count_read: assert property (p_count_read) else $error("count readback wrong");
  property p_irq_sticky;
    @(posedge ref_clk) disable iff (reset)
    delay_done_event[0] |=> irq_status[0];
  endproperty
  a_irq_sticky: assert property (p_irq_sticky) else $error("event lost from status");

  // ----------------------------------------
  // Line, register and interrupt checks
  // ----------------------------------------
  property p_line_settle;
    @(posedge ref_clk) disable iff (reset)
    (&line_agree) |=> line_ok == $past(line_s3);
  endproperty
  a_line_settle: assert property (p_line_settle) else $error("line level not taken");

  property p_unit_sel;
    @(posedge ref_clk) disable iff (reset)
    (wr_ok && hit_sel) |=> usel == $past(wd[0]);
  endproperty
  a_unit_sel: assert property (p_unit_sel) else $error("unit select not written");

  property p_lanes;
    @(posedge ref_clk) disable iff (reset)
    (avs_write && ack && avs_byteenable != `ALL_LANES)
      |=> $stable(usel) && $stable(irq_mask);
  endproperty
  a_lanes: assert property (p_lanes) else $error("partial write took effect");

  property p_clear_drops_begin;
    @(posedge ref_clk) disable iff (reset)
    (wr_ok && hit_clr_src && wd[4:0] != `SRC_OFF) |=> beg_src[usel] == `SRC_OFF;
  endproperty
  a_clear_drops_begin: assert property (p_clear_drops_begin) else $error("begin kept");

  property p_state_read;
    @(posedge ref_clk) disable iff (reset)
    (avs_read && avs_waitrequest && hit_state)
      |=> avs_readdata == {27'h000_0000, $past(state_now[usel])};
  endproperty
  a_state_read: assert property (p_state_read) else $error("state readback wrong");

  property p_clear_read;
    @(posedge ref_clk) disable iff (reset)
    (avs_read && avs_waitrequest && hit_at_clear)
      |=> avs_readdata == 32'($past(count_clr[usel]));
  endproperty
  a_clear_read: assert property (p_clear_read) else $error("captured count wrong");

  property p_irq_set_wins;
    @(posedge ref_clk) disable iff (reset)
    (|irq_events) |=> (irq_status & $past(irq_events)) == $past(irq_events);
  endproperty
  a_irq_set_wins: assert property (p_irq_set_wins) else $error("event lost to a clear");

  property p_irq_clear;
    @(posedge ref_clk) disable iff (reset)
    ((|irq_clear) && !(|irq_events)) |=> (irq_status & $past(irq_clear)) == '0;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("status bit not cleared");

  c_read: cover property (@(posedge ref_clk) disable iff (reset) avs_read && !avs_waitrequest);
  c_irq: cover property (@(posedge ref_clk) disable iff (reset) irq);
endmodule : dual_event_counter_timer

// [hdl/event_count_unit.sv]
`timescale 1ns/1ps
`include "counter_timer_defines.svh"
module event_count_unit #(
  parameter int COUNT_WIDTH = 32
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [`SRC_COUNT-1:0] sources,
  input wire logic [4:0] increment_source_select,
  input wire logic [2:0] increment_activation_mode,
  input wire logic [4:0] begin_source_select,
  input wire logic [2:0] begin_activation_mode,
  input wire logic [4:0] clear_source_select,
  input wire logic [2:0] clear_activation_mode,
  input wire logic [COUNT_WIDTH-1:0] start_delay_count,
  input wire logic [COUNT_WIDTH-1:0] run_length_count,
  output logic delay_done_event,
  output logic run_done_event,
  output logic [COUNT_WIDTH-1:0] present_count,
  output logic [COUNT_WIDTH-1:0] count_at_clear,
  output ctr_pkg::unit_state_t unit_state
);
  // ----------------------------------------
  // Source qualification
  // ----------------------------------------
  function automatic logic fires(input logic [`SRC_COUNT-1:0] now,
                                 input logic [`SRC_COUNT-1:0] prev,
                                 input logic [4:0] sel, input logic [2:0] mode);
    logic c;
    logic p;
    c = 1'b0;
    p = 1'b0;
    fires = 1'b0;
    if (sel != `SRC_OFF && sel < `SRC_LIMIT) begin
      c = now[sel];
      p = prev[sel];
      case (mode)
        `ACT_LOW: fires = !c;
        `ACT_HIGH: fires = c;
        `ACT_FALL: fires = p && !c;
        `ACT_RISE: fires = !p && c;
        `ACT_ANY: fires = p != c;
        default: fires = 1'b0;
      endcase
    end
  endfunction : fires

  logic [`SRC_COUNT-1:0] src_q;
  logic delay_seen;
  ctr_pkg::unit_state_t next_state;
  logic [COUNT_WIDTH-1:0] next_count;
  logic [COUNT_WIDTH-1:0] next_capture;
  logic next_seen;

  // Level modes fire every clock, edge modes once per transition
  wire inc_hit = fires(sources, src_q, increment_source_select, increment_activation_mode);
  wire begin_hit = fires(sources, src_q, begin_source_select, begin_activation_mode);
  wire clear_hit = fires(sources, src_q, clear_source_select, clear_activation_mode);
  wire unit_on = increment_source_select != `SRC_OFF;
  wire free_run = begin_source_select == `SRC_OFF;
  wire active = unit_state == ctr_pkg::st_active;
  wire at_max = &present_count;
  wire [COUNT_WIDTH-1:0] end_count = COUNT_WIDTH'(start_delay_count + run_length_count);
  wire delay_hit = active && !delay_seen && present_count == start_delay_count;
  // A zero duration ends in the same cycle as the delay, not never
  wire run_hit = active && (delay_seen || delay_hit) && present_count == end_count;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_state = unit_state;
    next_count = present_count;
    next_capture = count_at_clear;
    next_seen = delay_seen | delay_hit;
    if (!unit_on) begin
      next_state = ctr_pkg::st_idle;
      next_count = '0;
      next_seen = 1'b0;
    end else if (clear_hit) begin
      next_capture = present_count;
      next_count = '0;
      next_seen = 1'b0;
      next_state = free_run ? ctr_pkg::st_active : ctr_pkg::st_trigger_wait;
    end else begin
      case (unit_state)
        ctr_pkg::st_idle: next_state = free_run ? ctr_pkg::st_active : ctr_pkg::st_trigger_wait;
        ctr_pkg::st_trigger_wait, ctr_pkg::st_completed, ctr_pkg::st_overflow: begin
          if (begin_hit || (free_run && unit_state == ctr_pkg::st_trigger_wait)) begin
            next_state = ctr_pkg::st_active;
            next_count = '0;
            next_seen = 1'b0;
          end
        end
        ctr_pkg::st_active: begin
          if (run_hit) begin
            next_state = ctr_pkg::st_completed;
          end else if (inc_hit) begin
            // Holds at the top rather than wrapping silently
            if (at_max) begin
              next_state = ctr_pkg::st_overflow;
            end else begin
              next_count = present_count + 1'b1;
            end
          end
        end
        default: next_state = ctr_pkg::st_idle;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      src_q <= '0;
      unit_state <= ctr_pkg::st_idle;
      present_count <= '0;
      count_at_clear <= '0;
      delay_seen <= 1'b0;
      delay_done_event <= 1'b0;
      run_done_event <= 1'b0;
    end else begin
      src_q <= sources;
      unit_state <= next_state;
      present_count <= next_count;
      count_at_clear <= next_capture;
      delay_seen <= next_seen;
      delay_done_event <= delay_hit;
      run_done_event <= run_hit;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_delay_event;
    @(posedge ref_clk) disable iff (reset)
    delay_hit |=> delay_done_event ##1 !delay_done_event;
  endproperty
  a_delay_event: assert property (p_delay_event) else $error("start event missing");
  property p_run_event;
    @(posedge ref_clk) disable iff (reset)
    (run_hit && unit_on && !clear_hit) |=> run_done_event && unit_state == ctr_pkg::st_completed;
  endproperty
  a_run_event: assert property (p_run_event) else $error("end event missing");
  property p_pulse;
    @(posedge ref_clk) disable iff (reset)
    run_done_event |=> !run_done_event;
  endproperty
  a_pulse: assert property (p_pulse) else $error("end event longer than a cycle");
  property p_capture;
    @(posedge ref_clk) disable iff (reset)
    (clear_hit && unit_on) |=> count_at_clear == $past(present_count) && present_count == '0;
  endproperty
  a_capture: assert property (p_capture) else $error("count not captured at clear");
  property p_increment;
    @(posedge ref_clk) disable iff (reset)
    (active && inc_hit && !run_hit && !clear_hit && !at_max && unit_on)
      |=> present_count == COUNT_WIDTH'($past(present_count) + 1'b1);
  endproperty
  a_increment: assert property (p_increment) else $error("increment lost");
  property p_begin;
    @(posedge ref_clk) disable iff (reset)
    (unit_state == ctr_pkg::st_trigger_wait && begin_hit && !clear_hit && unit_on)
      |=> active && present_count == '0;
  endproperty
  a_begin: assert property (p_begin) else $error("begin did not start unit");
  property p_idle;
    @(posedge ref_clk) disable iff (reset)
    !unit_on |=> unit_state == ctr_pkg::st_idle;
  endproperty
  a_idle: assert property (p_idle) else $error("unit not idle");
  c_complete: cover property (@(posedge ref_clk) disable iff (reset) run_done_event);
  c_clear: cover property (@(posedge ref_clk) disable iff (reset) clear_hit && present_count != '0);
endmodule : event_count_unit

// [verif/camera_signal_model.sv]
`timescale 1ns/1ps
module camera_signal_model #(
  parameter int TICK_CYCLES = 250
) (
  input wire logic ref_clk,
  input wire logic reset,
  output logic microsecond_tick,
  output logic [3:0] line_in,
  output logic [3:0] software_output,
  output logic [1:0] programmable_logic_output,
  output logic exposure_begin,
  output logic exposure_finish,
  output logic awaiting_frame_trigger
);
  // ----------------------------------------
  // Source levels, indexed by source code
  // ----------------------------------------
  // Levels hold between pulses, as real phase signals do
  logic [18:0] level = '0;
  int tick_count;
  assign line_in = level[5:2];
  assign software_output = level[9:6];
  assign programmable_logic_output = level[15:14];
  assign exposure_begin = level[16];
  assign exposure_finish = level[17];
  assign awaiting_frame_trigger = level[18];
  // ----------------------------------------
  // Free-running tick
  // ----------------------------------------
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tick_count <= 0;
      microsecond_tick <= 1'b0;
    end else begin
      tick_count <= (tick_count == TICK_CYCLES - 1) ? 0 : tick_count + 1;
      microsecond_tick <= (tick_count == TICK_CYCLES - 1);
    end
  end
  // Called right after a rising edge only
  task automatic set_source(input int idx, input logic v);
    level[idx] <= v;
  endtask : set_source
endmodule : camera_signal_model

// [verif/dual_event_counter_timer_test.sv]
`timescale 1ns/1ps
`include "counter_timer_defines.svh"
module dual_event_counter_timer_test;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [5:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, irq, microsecond_tick, exposure_begin, exposure_finish;
  logic awaiting_frame_trigger;
  logic [3:0] line_in, software_output;
  logic [1:0] programmable_logic_output, delay_done_event, run_done_event;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int starts, ends, long_pulses;
  logic prev_start = 1'b0;
  logic prev_end = 1'b0;
  logic [31:0] q;
  always #2 ref_clk = ~ref_clk;
  dual_event_counter_timer #(.COUNT_WIDTH(32)) dut (.ref_clk(ref_clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .microsecond_tick(microsecond_tick), .line_in(line_in), .software_output(software_output),
    .programmable_logic_output(programmable_logic_output), .exposure_begin(exposure_begin),
    .exposure_finish(exposure_finish), .awaiting_frame_trigger(awaiting_frame_trigger),
    .delay_done_event(delay_done_event), .run_done_event(run_done_event));
  camera_signal_model #(.TICK_CYCLES(250)) model (.ref_clk(ref_clk), .reset(reset),
    .microsecond_tick(microsecond_tick), .line_in(line_in), .software_output(software_output),
    .programmable_logic_output(programmable_logic_output), .exposure_begin(exposure_begin),
    .exposure_finish(exposure_finish), .awaiting_frame_trigger(awaiting_frame_trigger));
  // ----------------------------------------
  // Event monitor and timeout
  // ----------------------------------------
  always @(posedge ref_clk) begin
    starts += delay_done_event[0];
    ends += run_done_event[0];
    if ((delay_done_event[0] && prev_start) || (run_done_event[0] && prev_end)) begin
      long_pulses++;
    end
    prev_start = delay_done_event[0];
    prev_end = run_done_event[0];
    cycles++;
    if (cycles == 40000) begin
      errors++;
      wrap_up();
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic wrap_up();
    $display("Checks %0d, errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] rdata);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf, q);
  endtask : wr
  task automatic rd_check(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hf, q);
    check(q, exp);
  endtask : rd_check
  task automatic pulse(input int idx, input int n);
    @(posedge ref_clk);
    model.set_source(idx, 1'b1);
    repeat (n) @(posedge ref_clk);
    model.set_source(idx, 1'b0);
    repeat (6) @(posedge ref_clk);
  endtask : pulse
  task automatic irq_check(input logic exp);
    @(negedge ref_clk);
    check({31'h0, irq}, {31'h0, exp});
  endtask : irq_check
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_values();
    rd_check(`OFS_STATE, 32'(ctr_pkg::st_idle));
    rd_check(`OFS_COUNT, 32'h0);
    rd_check(6'h3c, 32'h0);
    irq_check(1'b0);
    bus(1'b1, `OFS_UNIT_SEL, 32'h1, 4'h1, q);
    rd_check(`OFS_UNIT_SEL, 32'h0);
  endtask : t_reset_values
  task automatic t_delay_and_run();
    wr(`OFS_UNIT_SEL, 32'h1);
    wr(`OFS_DELAY, 32'h64);
    wr(`OFS_LENGTH, 32'h64);
    wr(`OFS_INC_ACT, 32'h1);
    wr(`OFS_INC_SRC, 32'ha);
    wr(`OFS_UNIT_SEL, 32'h0);
    wr(`OFS_DELAY, 32'h2);
    wr(`OFS_LENGTH, 32'h3);
    wr(`OFS_INC_ACT, 32'h1);
    wr(`OFS_INC_SRC, 32'h6);
    rd_check(`OFS_STATE, 32'(ctr_pkg::st_active));
    starts = 0;
    ends = 0;
    long_pulses = 0;
    pulse(6, 8);
    check(starts, 32'h1);
    check(ends, 32'h1);
    check(long_pulses, 32'h0);
    rd_check(`OFS_STATE, 32'(ctr_pkg::st_completed));
    wr(`OFS_UNIT_SEL, 32'h1);
    rd_check(`OFS_COUNT, 32'h1);
    irq_check(1'b0);
    wr(`OFS_IRQ_MASK, 32'h1);
    irq_check(1'b1);
    wr(`OFS_IRQ_STATUS, 32'h1);
    irq_check(1'b0);
    bus(1'b0, `OFS_IRQ_STATUS, 32'h0, 4'hf, q);
    check(q & 32'h5, 32'h4);
  endtask : t_delay_and_run
  task automatic t_begin_and_clear();
    wr(`OFS_INC_SRC, 32'h0);
    wr(`OFS_INC_ACT, 32'h3);
    wr(`OFS_BEG_ACT, 32'h3);
    wr(`OFS_BEG_SRC, 32'h8);
    wr(`OFS_INC_SRC, 32'h7);
    rd_check(`OFS_STATE, 32'(ctr_pkg::st_trigger_wait));
    pulse(7, 1);
    pulse(8, 1);
    rd_check(`OFS_STATE, 32'(ctr_pkg::st_active));
    rd_check(`OFS_COUNT, 32'h0);
    repeat (3) pulse(7, 1);
    rd_check(`OFS_COUNT, 32'h3);
    wr(`OFS_CLR_ACT, 32'h3);
    wr(`OFS_CLR_SRC, 32'h9);
    rd_check(`OFS_BEG_SRC, 32'h0);
    pulse(9, 1);
    rd_check(`OFS_AT_CLEAR, 32'h3);
    rd_check(`OFS_COUNT, 32'h0);
    rd_check(`OFS_STATE, 32'(ctr_pkg::st_active));
    repeat (2) pulse(7, 1);
    wr(`OFS_COUNT, 32'h7);
    rd_check(`OFS_COUNT, 32'h2);
    rd_check(`OFS_AT_CLEAR, 32'h3);
    wr(`OFS_BEG_SRC, 32'h8);
    rd_check(`OFS_CLR_SRC, 32'h0);
  endtask : t_begin_and_clear
  task automatic t_each_source();
    int srcs[13] = '{2, 3, 4, 5, 6, 7, 8, 9, 14, 15, 16, 17, 18};
    wr(`OFS_UNIT_SEL, 32'h0);
    wr(`OFS_DELAY, 32'h64);
    wr(`OFS_LENGTH, 32'h64);
    wr(`OFS_INC_ACT, 32'h3);
    foreach (srcs[i]) begin
      wr(`OFS_INC_SRC, 32'h0);
      wr(`OFS_INC_SRC, 32'(srcs[i]));
      pulse(srcs[i], 4);
      rd_check(`OFS_COUNT, 32'h1);
    end
  endtask : t_each_source
  task automatic t_each_mode();
    int modes[6] = '{0, 1, 2, 3, 4, 5};
    int counts[6] = '{7, 4, 1, 1, 2, 0};
    foreach (modes[i]) begin
      wr(`OFS_INC_SRC, 32'h0);
      wr(`OFS_INC_ACT, 32'(modes[i]));
      wr(`OFS_INC_SRC, 32'h7);
      pulse(7, 4);
      rd_check(`OFS_COUNT, 32'(counts[i]));
    end
  endtask : t_each_mode
  // Enabled just after a tick, so exactly two ticks fall in the window
  task automatic t_tick();
    wr(`OFS_INC_SRC, 32'h0);
    wr(`OFS_INC_ACT, 32'h3);
    do @(posedge ref_clk); while (microsecond_tick !== 1'b1);
    wr(`OFS_INC_SRC, 32'h1);
    repeat (500) @(posedge ref_clk);
    rd_check(`OFS_COUNT, 32'h2);
  endtask : t_tick
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset_values();
    t_delay_and_run();
    t_begin_and_clear();
    t_each_source();
    t_each_mode();
    t_tick();
    wrap_up();
  end
endmodule : dual_event_counter_timer_test
